/* verilog/nvw_pkg.sv */
// Package of constants for the serial nonvolatile memory write-protect block
// Functional notes
// - Latch flag is clear after power-up, so every write is refused.
// - Set-latch command sets the latch, allowing writes in later frames.
// - Status write data never writes the latch flag bit; the frame clears the latch.
// - Latch clears at chip-select rise after clear-latch, status or memory write.
// - Clear-latch command clears latch; status read then shows zero.
// - Write-guard pin low refuses all array and status writes.
// - Status: latch bit 1, guards bits 2 and 3, others read zero.
// - Block-guard bits are nonvolatile; latch flag reads zero after power-up.
// - Guard code 00 none, 01 180h-1FFh, 10 100h-1FFh, 11 everything.
// - Unprotected writes need latch set and guard pin high; protected never.
// - Status read returns exactly one status byte after the command.
// - Status write takes next byte into guard bits; counts as a write.
// - Opcode bit 3 is address bit 8; next byte is address 7..0.
// - Address increments per byte in bursts, wrapping 1FFh to 000h.
// - Burst write hitting a protected address stops and discards the rest.
// - Each write byte is stored right after its eighth bit.
// - A partly shifted byte is never stored.
// - Chip-select rise ends a write; new frame needs a new opcode.
// - After read opcode and address, drive data and ignore serial input.
// - Chip-select rise ends a read and releases the serial output.
// - All bytes shift most significant bit first.
// - Set-latch 06h, clear-latch 04h, status read 05h.
// - Status write 01h, read 0000A011b, write 0000A010b.
// - Sample input on rising, drive on falling; modes 0 and 3.
// - Unknown opcode ignored with rest of frame; output stays released.
package nvw_pkg;
    localparam logic [7:0] OPC_SET_LATCH  = 8'h06;
    localparam logic [7:0] OPC_CLR_LATCH  = 8'h04;
    localparam logic [7:0] OPC_STAT_READ  = 8'h05;
    localparam logic [7:0] OPC_STAT_WRITE = 8'h01;
    localparam logic [2:0] OPC_MEM_READ   = 3'h3;
    localparam logic [2:0] OPC_MEM_WRITE  = 3'h2;
    localparam int         OPC_ADDR_BIT   = 3;
    localparam int         STAT_LATCH_BIT = 1;
    localparam int         STAT_GUARD_LO  = 2;
    localparam int         STAT_GUARD_HI  = 3;
    localparam logic [1:0] GUARD_NONE     = 2'h0;
    localparam logic [1:0] GUARD_QUARTER  = 2'h1;
    localparam logic [1:0] GUARD_HALF     = 2'h2;
    localparam logic [8:0] QUARTER_BASE   = 9'h180;
    localparam logic [8:0] HALF_BASE      = 9'h100;
    localparam int         ADDR_W         = 9;
    localparam int         DEPTH          = 512;
    localparam int         SYNC_STAGES    = 3;
endpackage : nvw_pkg

/* verilog/nvw_sync.sv */
// Three-stage input synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module nvw_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    s1[i] <= INIT[i];
                    s2[i] <= INIT[i];
                    s3[i] <= INIT[i];
                    q[i]  <= INIT[i];
                end else begin
                    s1[i] <= d[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    // Change accepted only when stages two and three agree
                    if (s2[i] == s3[i]) begin
                        q[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate
endmodule : nvw_sync

/* verilog/nvw_core.sv */
// Serial slave command decoder, write latch, block guard and memory array
`timescale 1ns/1ps
module nvw_core #(
    parameter int DEPTH = nvw_pkg::DEPTH
) (
    // Core clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Serial link
    input  wire logic sck,
    input  wire logic cs_b,
    input  wire logic si,
    output logic      so,
    output logic      so_oe,
    // Write-guard pin, low refuses writes
    input  wire logic write_guard_b,
    // Latch state for observation
    output logic      write_latch_flag
);
    typedef enum logic [7:0] {
        ST_OPC   = 8'h01,
        ST_ADDR  = 8'h02,
        ST_WDATA = 8'h04,
        ST_RDATA = 8'h08,
        ST_SREAD = 8'h10,
        ST_SWRT  = 8'h20,
        ST_IDLE  = 8'h40,
        ST_SKIP  = 8'h80
    } nvw_state_e;

    // Link domain frame state
    nvw_state_e                   state;
    nvw_state_e                   next_state;
    logic [2:0]                   bit_cnt;
    logic [6:0]                   shift;
    logic [nvw_pkg::ADDR_W-1:0]   addr;
    logic [nvw_pkg::ADDR_W-1:0]   next_addr;
    logic                         is_write;
    logic                         next_is_write;
    logic                         burst_halt;
    logic                         next_burst_halt;
    logic [1:0]                   guard;
    logic                         set_tgl;
    logic                         clr_tgl;
    logic [7:0]                   mem [DEPTH];

    // Core domain latch state
    logic                         latch;
    logic                         clr_pend;
    logic                         cs_d;
    logic                         set_d;
    logic                         clr_d;
    logic [2:0]                   core_in;

    // Link domain view of latch and guard pin
    logic [1:0]                   link_in;
    logic                         latch_s;
    logic                         guard_pin_s;

    // Byte assembly and decode
    wire        byte_done = (bit_cnt == 3'h7);
    wire [7:0]  rx_byte   = {shift, si};
    wire        opc_set   = (rx_byte == nvw_pkg::OPC_SET_LATCH);
    wire        opc_clr   = (rx_byte == nvw_pkg::OPC_CLR_LATCH);
    wire        opc_srd   = (rx_byte == nvw_pkg::OPC_STAT_READ);
    wire        opc_swr   = (rx_byte == nvw_pkg::OPC_STAT_WRITE);
    wire        opc_mem   = (rx_byte[7:4] == 4'h0);
    wire        opc_mrd   = opc_mem
                          && (rx_byte[2:0] == nvw_pkg::OPC_MEM_READ);
    wire        opc_mwr   = opc_mem
                          && (rx_byte[2:0] == nvw_pkg::OPC_MEM_WRITE);
    wire        opc_clear = opc_clr || opc_swr || opc_mwr;

    // Block guard decode
    wire        addr_guarded =
        (guard == nvw_pkg::GUARD_NONE)    ? 1'b0 :
        (guard == nvw_pkg::GUARD_QUARTER) ? (addr >= nvw_pkg::QUARTER_BASE) :
        (guard == nvw_pkg::GUARD_HALF)    ? (addr >= nvw_pkg::HALF_BASE) :
                                            1'b1;
    wire        write_ok  = latch_s && guard_pin_s;
    wire        mem_store = (state == ST_WDATA) && byte_done && !burst_halt
                          && write_ok && !addr_guarded;
    wire        guard_store = (state == ST_SWRT) && byte_done
                            && write_ok;

    // Status byte: unused bits read zero
    wire [7:0]  status_byte = {4'h0, guard, latch_s, 1'b0};
    wire [7:0]  tx_byte     = (state == ST_SREAD) ? status_byte
                                                  : mem[addr];
    wire        tx_active   = (state == ST_SREAD) || (state == ST_RDATA);

    // Next-state logic for the link frame
    always_comb begin
        next_state      = state;
        next_addr       = addr;
        next_is_write   = is_write;
        next_burst_halt = burst_halt;
        if (byte_done) begin
            unique case (state)
                ST_OPC: begin
                    next_addr[nvw_pkg::ADDR_W-1] =
                        rx_byte[nvw_pkg::OPC_ADDR_BIT];
                    if (opc_srd) begin
                        next_state = ST_SREAD;
                    end else if (opc_swr) begin
                        next_state = ST_SWRT;
                    end else if (opc_mrd || opc_mwr) begin
                        next_state    = ST_ADDR;
                        next_is_write = opc_mwr;
                    end else if (opc_set || opc_clr) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    next_addr[7:0] = rx_byte;
                    next_state     = is_write ? ST_WDATA : ST_RDATA;
                end
                ST_WDATA: begin
                    if (burst_halt || addr_guarded || !write_ok) begin
                        next_burst_halt = 1'b1;
                    end else begin
                        next_addr = addr + 9'h001;
                    end
                end
                ST_RDATA: begin
                    next_addr = addr + 9'h001;
                end
                ST_SREAD: begin
                    next_state = ST_IDLE;
                end
                ST_SWRT: begin
                    next_state = ST_IDLE;
                end
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_SKIP: begin
                    next_state = ST_SKIP;
                end
            endcase
        end
    end

    // Frame logic, cleared while chip select is high
    always_ff @(posedge sck or posedge cs_b) begin
        if (cs_b) begin
            state      <= ST_OPC;
            bit_cnt    <= 3'h0;
            shift      <= 7'h00;
            addr       <= '0;
            is_write   <= 1'b0;
            burst_halt <= 1'b0;
        end else begin
            bit_cnt    <= bit_cnt + 3'h1;
            shift      <= rx_byte[6:0];
            state      <= next_state;
            addr       <= next_addr;
            is_write   <= next_is_write;
            burst_halt <= next_burst_halt;
        end
    end

    // Latch requests leave the link domain as toggles
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            set_tgl <= 1'b0;
            clr_tgl <= 1'b0;
        end else if (!cs_b && (state == ST_OPC) && byte_done) begin
            if (opc_set) begin
                set_tgl <= ~set_tgl;
            end
            if (opc_clear) begin
                clr_tgl <= ~clr_tgl;
            end
        end
    end

    // Guard bits are nonvolatile and carry no reset
    always_ff @(posedge sck) begin
        if (!cs_b && guard_store) begin
            guard <= rx_byte[nvw_pkg::STAT_GUARD_HI:
                             nvw_pkg::STAT_GUARD_LO];
        end
    end

    // Array write at the eighth bit of each byte
    always_ff @(posedge sck) begin
        if (!cs_b && mem_store) begin
            mem[addr] <= rx_byte;
        end
    end

    // Output shifts on falling edges; released outside read phases
    always_ff @(negedge sck or posedge cs_b) begin
        if (cs_b) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so    <= tx_byte[~bit_cnt];
            so_oe <= tx_active;
        end
    end

    // Latch state and guard pin seen from the link domain
    nvw_sync #(
        .WIDTH (2),
        .INIT  (2'b01)
    ) u_link_sync (
        .clk   (sck),
        .rst_b (rst_b),
        .d     ({latch, write_guard_b}),
        .q     (link_in)
    );
    assign latch_s     = link_in[1];
    assign guard_pin_s = link_in[0];

    // Chip select and toggles seen from the core domain
    nvw_sync #(
        .WIDTH (3),
        .INIT  (3'b100)
    ) u_core_sync (
        .clk   (ref_clk),
        .rst_b (rst_b),
        .d     ({cs_b, set_tgl, clr_tgl}),
        .q     (core_in)
    );

    wire cs_s     = core_in[2];
    wire set_evt  = core_in[1] ^ set_d;
    wire clr_evt  = core_in[0] ^ clr_d;
    wire cs_rise  = cs_s && !cs_d;

    // Write latch, cleared at the end of a clearing frame
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            latch    <= 1'b0;
            clr_pend <= 1'b0;
            cs_d     <= 1'b1;
            set_d    <= 1'b0;
            clr_d    <= 1'b0;
        end else begin
            cs_d  <= cs_s;
            set_d <= core_in[1];
            clr_d <= core_in[0];
            if (set_evt) begin
                latch <= 1'b1;
            end else if (cs_rise && (clr_pend || clr_evt)) begin
                latch <= 1'b0;
            end
            if (clr_evt && !cs_rise) begin
                clr_pend <= 1'b1;
            end else if (cs_rise) begin
                clr_pend <= 1'b0;
            end
        end
    end

    assign write_latch_flag = latch;
endmodule : nvw_core

/* sim/nvw_core_checker.sv */
// Port checker for the write-protect memory block
`timescale 1ns/1ps
module nvw_core_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Serial link and pins
    input wire logic sck,
    input wire logic cs_b,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic write_guard_b,
    input wire logic write_latch_flag
);
    logic [5:0] cnt;
    logic [7:0] opc;
    logic [7:0] frm_op;
    logic       frm_full;
    wire        is_rd  = opc[7:4] == 4'h0 && opc[2:0] == 3'h3;
    wire        wr_op  = frm_op[7:4] == 4'h0 && frm_op[2:0] == 3'h2;
    wire        clr_op = wr_op || frm_op == 8'h04 || frm_op == 8'h01;
    // Bit count and opcode of the current frame
    always_ff @(posedge sck or posedge cs_b) begin
        if (cs_b) begin
            cnt <= 6'h00;
            opc <= 8'h00;
        end else begin
            cnt <= (cnt == 6'h3f) ? cnt : cnt + 6'h01;
            opc <= (cnt < 6'h08) ? {opc[6:0], si} : opc;
        end
    end
    // Opcode of the frame as seen by the core clock
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            frm_full <= 1'b0;
            frm_op   <= 8'h00;
        end else if (!cs_b) begin
            frm_full <= cnt >= 6'h08;
            frm_op   <= opc;
        end
    end
    reset_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(rst_b) |-> !write_latch_flag) else $error("latch set after reset");
    cs_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cs_b |-> !so_oe) else $error("output driven while deselected");
    latch_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(cs_b) && frm_full && frm_op == 8'h06 |-> ##[1:8] write_latch_flag)
        else $error("latch not set");
    latch_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(cs_b) && frm_full && clr_op |-> ##[1:8] !write_latch_flag)
        else $error("latch not cleared");
    stat_len_a: assert property (@(posedge sck) disable iff (!rst_b || cs_b)
        cnt == 6'h08 && opc == 8'h05 |-> so_oe [*8] ##1 !so_oe)
        else $error("status byte length wrong");
    stat_zero_a: assert property (@(posedge sck) disable iff (!rst_b || cs_b)
        cnt == 6'h08 && opc == 8'h05 |-> !so [*4] ##4 !so)
        else $error("fixed status bits not zero");
    stat_latch_a: assert property (@(posedge sck) disable iff (!rst_b || cs_b)
        cnt == 6'h0e && opc == 8'h05 |-> so == write_latch_flag)
        else $error("status latch bit wrong");
    unk_quiet_a: assert property (@(posedge sck) disable iff (!rst_b || cs_b)
        cnt >= 6'h08 && opc != 8'h05 && !is_rd |-> !so_oe)
        else $error("output driven for non-read opcode");
    read_drive_a: assert property (@(posedge sck) disable iff (!rst_b || cs_b)
        cnt == 6'h10 && is_rd |-> so_oe) else $error("read data not driven");
    early_quiet_a: assert property (@(posedge sck) disable iff (!rst_b || cs_b)
        cnt < 6'h08 |-> !so_oe) else $error("output driven during opcode");
endmodule : nvw_core_checker

bind nvw_core nvw_core_checker u_chk (.ref_clk, .rst_b, .sck, .cs_b, .si, .so,
    .so_oe, .write_guard_b, .write_latch_flag);

/* sim/nvw_spi_master.sv */
// Serial bus master model driving the memory's link pins
`timescale 1ns/1ps
module nvw_spi_master (
    // Link pins
    output logic      sck,
    output logic      cs_b,
    output logic      si,
    input  wire logic so
);
    logic cpol = 1'b0;
    initial begin
        sck  = 1'b0;
        cs_b = 1'b1;
        si   = 1'b0;
    end
    // Clock idles at the mode's level when selecting
    task automatic open_frame(input logic mode3);
        cpol = mode3;
        sck  = mode3;
        #2 cs_b = 1'b0;
        #3;
    endtask : open_frame
    // Drive on falling, sample on rising, MSB first
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            sck = 1'b0;
            si  = tx[i];
            #3 sck = 1'b1;
            rx[i] = so;
            #3;
        end
    endtask : shift
    // Clock returns to its idle level, then deselect and invert the data input
    task automatic close_frame();
        sck = cpol;
        #5 cs_b = 1'b1;
        si = ~si;
        #40;
    endtask : close_frame
endmodule : nvw_spi_master

/* sim/nvw_core_tb.sv */
// Testbench for the write-protect memory block
`timescale 1ns/1ps
module nvw_core_tb;
    logic       ref_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       write_guard_b = 1'b1;
    wire        sck, cs_b, si, so, so_oe, write_latch_flag;
    wire        so_line = so_oe ? so : ~so;
    logic [7:0] shadow [512];
    logic [1:0] gd = 2'h0;
    logic       lat = 1'b0;
    logic [7:0] rx;
    int         error_cnt = 0, checks_done = 0, cyc = 0;

    nvw_core u_dut (.ref_clk, .rst_b, .sck, .cs_b, .si, .so, .so_oe,
                    .write_guard_b, .write_latch_flag);
    nvw_spi_master u_mst (.sck, .cs_b, .si, .so(so_line));

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [7:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic prot(input logic [8:0] a);
        return gd == 2'h3 || (gd == 2'h2 && a >= 9'h100)
            || (gd == 2'h1 && a >= 9'h180);
    endfunction : prot
    task automatic cmd(input logic [7:0] op, input int n);
        u_mst.open_frame(1'b0);
        u_mst.shift(op, n, rx);
        u_mst.close_frame();
        if (n == 8 && op == 8'h06) lat = 1'b1;
        if (n == 8 && op == 8'h04) lat = 1'b0;
        chk("latch", {7'h00, lat}, {7'h00, write_latch_flag});
    endtask : cmd
    task automatic wstat(input logic [7:0] v);
        cmd(8'h06, 8);
        u_mst.open_frame(1'b0);
        u_mst.shift(8'h01, 8, rx);
        u_mst.shift(v, 8, rx);
        u_mst.close_frame();
        if (write_guard_b) gd = v[3:2];
        lat = 1'b0;
        chk("latch", {7'h00, lat}, {7'h00, write_latch_flag});
    endtask : wstat
    task automatic rstat(input logic mode3);
        u_mst.open_frame(mode3);
        u_mst.shift(8'h05, 8, rx);
        u_mst.shift(8'h00, 8, rx);
        u_mst.close_frame();
        chk("status", {4'h0, gd, lat, 1'b0}, rx);
    endtask : rstat
    task automatic wmem(input logic [8:0] a, input int n,
                        input logic [7:0] d, input int pb, input logic en);
        logic stop;
        stop = 1'b0;
        if (en) cmd(8'h06, 8);
        u_mst.open_frame(1'b0);
        u_mst.shift({4'h0, a[8], 3'h2}, 8, rx);
        u_mst.shift(a[7:0], 8, rx);
        for (int k = 0; k < n; k++) begin
            stop = stop || !lat || !write_guard_b || prot(a);
            if (!stop) shadow[a] = d + 8'(k);
            u_mst.shift(d + 8'(k), 8, rx);
            a = a + 9'h001;
        end
        if (pb > 0) u_mst.shift(~shadow[a], pb, rx);
        u_mst.close_frame();
        lat = 1'b0;
        chk("latch", {7'h00, lat}, {7'h00, write_latch_flag});
    endtask : wmem
    task automatic rmem(input logic [8:0] a, input int n);
        u_mst.open_frame(1'b0);
        u_mst.shift({4'h0, a[8], 3'h3}, 8, rx);
        u_mst.shift(a[7:0], 8, rx);
        for (int k = 0; k < n; k++) begin
            u_mst.shift(8'h06, 8, rx);
            chk("read data", shadow[a + 9'(k)], rx);
        end
        u_mst.close_frame();
    endtask : rmem
    task automatic t_latch();
        wstat(8'hf3);
        rstat(1'b0);
        rstat(1'b1);
        cmd(8'h06, 8);
        rstat(1'b0);
        cmd(8'h04, 5);
        cmd(8'hff, 8);
        rstat(1'b1);
        cmd(8'h04, 8);
        rstat(1'b0);
    endtask : t_latch
    task automatic t_burst();
        wmem(9'h000, 512, 8'h00, 0, 1'b1);
        wmem(9'h1fe, 6, 8'ha0, 4, 1'b1);
        rmem(9'h1fd, 8);
        wmem(9'h010, 2, 8'h77, 0, 1'b0);
        rmem(9'h00f, 4);
    endtask : t_burst
    task automatic t_guard();
        logic [8:0] b;
        for (int g = 1; g < 4; g++) begin
            b = (g == 1) ? 9'h180 : (g == 2) ? 9'h100 : 9'h000;
            wstat({4'h0, 2'(g), 2'h0});
            rstat(1'b0);
            wmem(b - 9'h001, 3, 8'hc0 + 8'(g), 0, 1'b1);
            rmem(b - 9'h002, 5);
        end
        wstat(8'h00);
    endtask : t_guard
    task automatic t_pin();
        @(posedge ref_clk) #1 write_guard_b = 1'b0;
        wstat(8'h0c);
        rstat(1'b0);
        wmem(9'h020, 2, 8'h3c, 0, 1'b1);
        rmem(9'h020, 2);
        @(posedge ref_clk) #1 write_guard_b = 1'b1;
    endtask : t_pin
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("latch after reset", 8'h00, {7'h00, write_latch_flag});
        t_latch();
        t_burst();
        t_guard();
        t_pin();
        finish_test();
    end
endmodule : nvw_core_tb
